// [lfd_pkg.sv]
//==========================================================================
package lfd_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned ERR_PULSE_US = 50;
  localparam int unsigned ERR_PULSE_CYC = ERR_PULSE_US * CLK_MHZ;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [3:0] WD_OFF = 4'h0;
  localparam logic [3:0] WD_FORCE = 4'hF;
  // threshold code: volts = 2.5 + 0.125 * code, so code 255 is 34.375 V
  localparam int unsigned THR_BASE_MV = 2500;
  localparam int unsigned THR_STEP_MV = 125;
  localparam int unsigned RECOVER_HYST_MV = 275;

  typedef enum logic [1:0] {
    LFD_IDLE = 2'b00,
    LFD_LOAD = 2'b01,
    LFD_WAIT = 2'b11,
    LFD_CHECK = 2'b10
  } lfd_load_t;

  // one msb-first crc step per input bit, eight per byte
  function automatic logic [7:0] lfd_crc_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[7] ^ data[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : lfd_crc_byte
endpackage : lfd_pkg

// [lfd_nvm_mem.sv]
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// nvm shadow image, registered read data
module lfd_nvm_mem #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW = 5
) (
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [DEPTH];
  initial begin
    if (DEPTH > (1 << AW)) $error("lfd_nvm_mem depth too large");
  end
  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : lfd_nvm_mem
`default_nettype wire

// [lfd_diag.sv]
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// normal-state diagnostics, nvm crc check and communication watchdog
module lfd_diag
  import lfd_pkg::*;
#(
  parameter int unsigned CH = 16,
  parameter int unsigned DEG_W = 12,
  parameter int unsigned NVM_BYTES = 32,
  parameter int unsigned NVM_AW = 5,
  parameter int unsigned RSV_DIM_IDX = 30,
  parameter int unsigned CRC_IDX = 31,
  parameter int unsigned WD_UNIT_CYC = 250_000,
  parameter int unsigned PULSE_CYC = ERR_PULSE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // analog comparator and pwm levels from other clock/analog domain
  input wire logic [CH-1:0] i_pwm_on,
  input wire logic [CH-1:0] i_short_cmp,
  input wire logic [CH-1:0] i_sls_cmp0,
  input wire logic [CH-1:0] i_sls_cmp1,
  input wire logic i_low_supply,
  // configuration
  input wire logic [DEG_W-1:0] i_blank_cyc,
  input wire logic [DEG_W-1:0] i_short_deg_cyc,
  input wire logic [DEG_W-1:0] i_sls_deg_cyc,
  input wire logic i_single_led_short_enable,
  input wire logic [CH-1:0] i_channel_threshold_select,
  input wire logic [3:0] i_watchdog_period_setting,
  // host command pulses
  input wire logic i_clear_fault_bit,
  input wire logic i_clear_failsafe_bit,
  input wire logic i_register_default_reload,
  // bus events from framing logic on this clock
  input wire logic i_bus_idle,
  input wire logic i_good_frame,
  // nvm load stream
  input wire logic i_nvm_valid,
  input wire logic [7:0] i_nvm_data,
  output logic o_nvm_req,
  input wire logic i_trim_valid,
  input wire logic [8:0] i_trim_data,
  // status
  output logic [CH-1:0] o_channel_short_flag,
  output logic [CH-1:0] o_channel_single_led_flag,
  output logic o_out_flag,
  output logic o_err_flag,
  output logic o_nvm_crc_error_flag,
  output logic o_trim_parity_flag,
  output logic o_failsafe_flag,
  output logic [7:0] o_computed_nvm_crc,
  output logic [7:0] o_stored_nvm_crc,
  output logic o_clear_fault_bit,
  output logic o_err_pin_oe
);
  import lfd_pkg::*;

  initial begin
    if (CH < 1 || CH > 32) $error("lfd_diag channel count out of range");
    if (CRC_IDX >= NVM_BYTES || RSV_DIM_IDX >= NVM_BYTES) $error("lfd_diag nvm index");
    if (NVM_BYTES > (1 << NVM_AW)) $error("lfd_diag nvm address width");
  end

  localparam int unsigned PW = $clog2(PULSE_CYC + 1);
  localparam int unsigned WW = $clog2(WD_UNIT_CYC * 15 + 1);

  //==========================================================================
  // input synchronisers
  logic [CH-1:0] pwm_m, pwm_s, sh_m, sh_s, c0_m, c0_s, c1_m, c1_s;
  logic ls_m, ls_s;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwm_m <= '0;
      pwm_s <= '0;
      sh_m <= '0;
      sh_s <= '0;
      c0_m <= '0;
      c0_s <= '0;
      c1_m <= '0;
      c1_s <= '0;
      ls_m <= 1'b0;
      ls_s <= 1'b0;
    end else if (i_ce) begin
      pwm_m <= i_pwm_on;
      pwm_s <= pwm_m;
      sh_m <= i_short_cmp;
      sh_s <= sh_m;
      c0_m <= i_sls_cmp0;
      c0_s <= c0_m;
      c1_m <= i_sls_cmp1;
      c1_s <= c1_m;
      ls_m <= i_low_supply;
      ls_s <= ls_m;
    end
  end

  //==========================================================================
  // per-channel deglitch timers
  logic [DEG_W:0] sh_lim, sls_lim;
  logic [CH-1:0] sh_hit, sls_hit, sls_cond;
  logic [DEG_W:0] sh_cnt [CH];
  logic [DEG_W:0] sls_cnt [CH];
  assign sh_lim = {1'b0, i_blank_cyc} + {1'b0, i_short_deg_cyc};
  assign sls_lim = {1'b0, i_blank_cyc} + {1'b0, i_sls_deg_cyc};

  always_comb begin
    for (int c = 0; c < CH; c++) begin
      sls_cond[c] = i_single_led_short_enable && !ls_s &&
        (i_channel_threshold_select[c] ? c1_s[c] : c0_s[c]);
      sh_hit[c] = pwm_s[c] && sh_s[c] && (sh_cnt[c] == sh_lim);
      sls_hit[c] = pwm_s[c] && sls_cond[c] && (sls_cnt[c] == sls_lim);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int c = 0; c < CH; c++) begin
        sh_cnt[c] <= '0;
        sls_cnt[c] <= '0;
      end
    end else if (i_ce) begin
      for (int c = 0; c < CH; c++) begin
        if (!(pwm_s[c] && sh_s[c])) begin
          sh_cnt[c] <= '0;
        end else if (sh_cnt[c] != sh_lim) begin
          sh_cnt[c] <= sh_cnt[c] + 1'b1;
        end
        if (!(pwm_s[c] && sls_cond[c])) begin
          sls_cnt[c] <= '0;
        end else if (sls_cnt[c] != sls_lim) begin
          sls_cnt[c] <= sls_cnt[c] + 1'b1;
        end
      end
    end
  end

  //==========================================================================
  // clear-fault bit self-returns one cycle later
  logic clr_fault;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clr_fault <= 1'b0;
    end else if (i_ce) begin
      clr_fault <= i_clear_fault_bit && !clr_fault;
    end
  end
  assign o_clear_fault_bit = clr_fault;

  //==========================================================================
  // nvm load and crc check
  lfd_load_t ld_state;
  logic [NVM_AW-1:0] ld_idx;
  logic [7:0] crc;
  logic crc_mismatch_ev, trim_err_ev;
  logic [7:0] mem_rd;

  lfd_nvm_mem #(
    .DEPTH(NVM_BYTES),
    .AW(NVM_AW)
  ) u_mem (
    .i_clk(i_clk),
    .i_ce(i_ce),
    .i_we(ld_state == LFD_LOAD && i_nvm_valid),
    .i_waddr(ld_idx),
    .i_wdata(i_nvm_data),
    .i_raddr(NVM_AW'(CRC_IDX)),
    .o_rdata(mem_rd)
  );
  assign o_nvm_req = (ld_state == LFD_LOAD);

  // load at init, reload on request
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ld_state <= LFD_LOAD;
      ld_idx <= '0;
      crc <= CRC_INIT;
      o_stored_nvm_crc <= '0;
      o_computed_nvm_crc <= '0;
      crc_mismatch_ev <= 1'b0;
    end else if (i_ce) begin
      crc_mismatch_ev <= 1'b0;
      case (ld_state)
        LFD_IDLE: begin
          if (i_register_default_reload) begin
            ld_state <= LFD_LOAD;
            ld_idx <= '0;
            crc <= CRC_INIT;
          end
        end
        LFD_LOAD: begin
          if (i_nvm_valid) begin
            // crc skips reserved and crc bytes
            if (ld_idx != NVM_AW'(RSV_DIM_IDX) && ld_idx != NVM_AW'(CRC_IDX)) begin
              crc <= lfd_crc_byte(crc, i_nvm_data);
            end
            if (ld_idx == NVM_AW'(NVM_BYTES - 1)) begin
              ld_state <= LFD_WAIT;
            end else begin
              ld_idx <= ld_idx + 1'b1;
            end
          end
        end
        // registered memory read lags the last write by one cycle
        LFD_WAIT: begin
          ld_state <= LFD_CHECK;
        end
        LFD_CHECK: begin
          o_computed_nvm_crc <= crc;
          o_stored_nvm_crc <= mem_rd;
          crc_mismatch_ev <= (crc != mem_rd);
          ld_state <= LFD_IDLE;
        end
        default: ld_state <= LFD_IDLE;
      endcase
    end
  end

  assign trim_err_ev = i_trim_valid && (^i_trim_data);

  //==========================================================================
  // latched flags; set wins over clear. no action, report only
  logic any_ev;
  assign any_ev = (|sh_hit) || (|sls_hit) || crc_mismatch_ev || trim_err_ev;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_channel_short_flag <= '0;
      o_channel_single_led_flag <= '0;
      o_out_flag <= 1'b0;
      o_err_flag <= 1'b0;
      o_nvm_crc_error_flag <= 1'b0;
      o_trim_parity_flag <= 1'b0;
    end else if (i_ce) begin
      o_channel_short_flag <= (clr_fault ? '0 : o_channel_short_flag) | sh_hit;
      o_channel_single_led_flag <= (clr_fault ? '0 : o_channel_single_led_flag) | sls_hit;
      o_out_flag <= (o_out_flag && !clr_fault) || (|sh_hit) || (|sls_hit);
      o_err_flag <= (o_err_flag && !clr_fault) || any_ev;
      o_nvm_crc_error_flag <= (o_nvm_crc_error_flag && !clr_fault) || crc_mismatch_ev;
      o_trim_parity_flag <= (o_trim_parity_flag && !clr_fault) || trim_err_ev;
    end
  end

  logic [PW-1:0] pulse_cnt;
  logic new_ev;
  assign new_ev = (|(sh_hit & ~o_channel_short_flag)) ||
    (|(sls_hit & ~o_channel_single_led_flag)) || crc_mismatch_ev;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_cnt <= '0;
    end else if (i_ce) begin
      if (new_ev) begin
        pulse_cnt <= PW'(PULSE_CYC);
      end else if (pulse_cnt != '0) begin
        pulse_cnt <= pulse_cnt - 1'b1;
      end
    end
  end
  assign o_err_pin_oe = (pulse_cnt != '0);

  //==========================================================================
  // communication watchdog
  logic [WW-1:0] wd_cnt, wd_lim;
  assign wd_lim = WW'(WD_UNIT_CYC) * WW'(i_watchdog_period_setting);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wd_cnt <= '0;
      o_failsafe_flag <= 1'b0;
    end else if (i_ce) begin
      if (i_good_frame) begin
        wd_cnt <= '0;
      end else if (i_bus_idle && i_watchdog_period_setting != WD_OFF && wd_cnt != wd_lim) begin
        wd_cnt <= wd_cnt + 1'b1;
      end
      if (i_watchdog_period_setting == WD_FORCE ||
          (i_watchdog_period_setting != WD_OFF && wd_cnt == wd_lim)) begin
        o_failsafe_flag <= 1'b1;
      end else if (i_clear_failsafe_bit) begin
        o_failsafe_flag <= 1'b0;
      end
    end
  end
endmodule : lfd_diag
`default_nettype wire

// [lfd_diag_props.sv]
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// port checker
module lfd_diag_props #(
  parameter int unsigned CH = 16,
  parameter int unsigned PULSE_CYC = 12500
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_single_led_short_enable,
  input wire logic [3:0] i_watchdog_period_setting,
  input wire logic i_clear_fault_bit,
  input wire logic i_clear_failsafe_bit,
  input wire logic [CH-1:0] o_channel_short_flag,
  input wire logic [CH-1:0] o_channel_single_led_flag,
  input wire logic o_out_flag,
  input wire logic o_err_flag,
  input wire logic o_failsafe_flag,
  input wire logic o_clear_fault_bit,
  input wire logic o_err_pin_oe
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // length of the current error-pin pulse; a retrigger only lengthens it
  int unsigned hi_cnt;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_cnt <= 0;
    end else begin
      hi_cnt <= o_err_pin_oe ? hi_cnt + 1 : 0;
    end
  end
  a_clear_follows_req: assert property (i_clear_fault_bit |=> o_clear_fault_bit)
    else $error("clear bit not set");
  a_clear_self_return: assert property (o_clear_fault_bit |=> !o_clear_fault_bit)
    else $error("clear bit stuck");
  a_err_flag_latched: assert property ($fell(o_err_flag) |-> $past(o_clear_fault_bit))
    else $error("error flag dropped");
  a_chan_flag_latched: assert property
    (($past(o_channel_short_flag) & ~o_channel_short_flag) != '0 |-> $past(o_clear_fault_bit))
    else $error("short flag dropped");
  a_summary_flags: assert property
    ((o_channel_short_flag | o_channel_single_led_flag) != '0 |-> o_out_flag && o_err_flag)
    else $error("summary flag missing");
  a_sls_needs_enable: assert property
    ((o_channel_single_led_flag & ~$past(o_channel_single_led_flag)) != '0
      |-> $past(i_single_led_short_enable))
    else $error("single-led flag while disabled");
  a_pulse_steady: assert property ($rose(o_err_pin_oe) |=> o_err_pin_oe [*8])
    else $error("error pulse too short");
  a_pulse_length: assert property ($fell(o_err_pin_oe) |-> hi_cnt >= PULSE_CYC)
    else $error("error pulse length wrong");
  a_pulse_has_flag: assert property ($rose(o_err_pin_oe) |-> o_err_flag)
    else $error("pulse without error flag");
  a_fs_needs_period: assert property
    ($rose(o_failsafe_flag) |-> $past(i_watchdog_period_setting) != 4'h0)
    else $error("fail-safe with watchdog off");
  a_fs_latched: assert property ($fell(o_failsafe_flag) |-> $past(i_clear_failsafe_bit) ||
    $past(i_clear_failsafe_bit, 2) || $past(i_clear_failsafe_bit, 3))
    else $error("fail-safe dropped");
endmodule : lfd_diag_props
bind lfd_diag lfd_diag_props #(.CH(CH), .PULSE_CYC(PULSE_CYC)) props_u (.*);
`default_nettype wire

// [lfd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// host on the serial bus
module lfd_host_model (
  input wire logic i_clk,
  output logic o_bus_idle,
  output logic o_good_frame,
  output logic o_clear_fault,
  output logic o_clear_failsafe,
  output logic o_reload
);
  initial begin
    o_bus_idle = 1'b1;
    o_good_frame = 1'b0;
    {o_reload, o_clear_failsafe, o_clear_fault} = 3'h0;
  end
  // addressed frame: bus busy, then one good pulse
  task automatic frame();
    @(negedge i_clk);
    o_bus_idle = 1'b0;
    @(negedge i_clk);
    o_good_frame = 1'b1;
    @(negedge i_clk);
    o_good_frame = 1'b0;
    o_bus_idle = 1'b1;
  endtask : frame
  task automatic write_cmd(input logic [2:0] c);
    @(negedge i_clk);
    {o_reload, o_clear_failsafe, o_clear_fault} = c;
    @(negedge i_clk);
    {o_reload, o_clear_failsafe, o_clear_fault} = 3'h0;
  endtask : write_cmd
endmodule : lfd_host_model
`default_nettype wire

// [led_fault_diag_watchdog_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// bench top
module led_fault_diag_watchdog_tb_top;
  import lfd_pkg::*;
  localparam int unsigned CH = 4;
  logic i_clk, i_rst_n, i_ce, i_low_supply, i_single_led_short_enable, i_bus_idle;
  logic i_good_frame, i_nvm_valid, i_trim_valid, o_out_flag, o_err_flag, o_nvm_req;
  logic o_nvm_crc_error_flag, o_trim_parity_flag, o_failsafe_flag, o_clear_fault_bit;
  logic i_clear_fault_bit, i_clear_failsafe_bit, i_register_default_reload, o_err_pin_oe;
  logic [CH-1:0] i_pwm_on, i_short_cmp, i_sls_cmp0, i_sls_cmp1, i_channel_threshold_select;
  logic [CH-1:0] o_channel_short_flag, o_channel_single_led_flag;
  logic [11:0] i_blank_cyc, i_short_deg_cyc, i_sls_deg_cyc;
  logic [3:0] i_watchdog_period_setting;
  logic [7:0] i_nvm_data, o_computed_nvm_crc, o_stored_nvm_crc;
  logic [8:0] i_trim_data;
  int mismatches, compares, cycles;

  // short counts keep the run brief: 10-cycle watchdog step, 20-cycle error pulse
  lfd_diag #(.CH(CH), .WD_UNIT_CYC(10), .PULSE_CYC(20)) dut_u (.*);
  lfd_host_model host_u (.i_clk(i_clk), .o_bus_idle(i_bus_idle), .o_good_frame(i_good_frame),
    .o_clear_fault(i_clear_fault_bit), .o_clear_failsafe(i_clear_failsafe_bit),
    .o_reload(i_register_default_reload));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_clk);
  endtask : wait_n
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc_step
  task automatic load_nvm(input logic bad);
    logic [7:0] crc;
    crc = CRC_INIT;
    for (int k = 0; k < 50 && o_nvm_req !== 1'b1; k++)
      @(negedge i_clk);
    for (int i = 0; i < 32; i++) begin
      @(negedge i_clk);
      i_nvm_valid = 1'b1;
      i_nvm_data = (i == 31) ? (crc ^ {7'h00, bad}) : 8'(i * 5 + 3);
      if (i < 30) crc = crc_step(crc, i_nvm_data);
    end
    @(negedge i_clk);
    i_nvm_valid = 1'b0;
    i_trim_valid = 1'b1;
    i_trim_data = bad ? 9'h001 : 9'h003;
    @(negedge i_clk);
    i_trim_valid = 1'b0;
    wait_n(4);
    chk(o_computed_nvm_crc, crc);
    chk(o_stored_nvm_crc, crc ^ {7'h00, bad});
    chk({o_nvm_crc_error_flag, o_err_pin_oe}, {bad, bad});
    chk(o_trim_parity_flag, bad);
    $display("nvm load test done");
  endtask : load_nvm
  task automatic clear_fault();
    host_u.write_cmd(3'h1);
    chk(o_clear_fault_bit, 1'b1);
    @(negedge i_clk);
    chk(o_clear_fault_bit, 1'b0);
    chk({o_channel_short_flag, o_channel_single_led_flag, o_err_flag, o_out_flag}, 10'h000);
    chk(o_nvm_crc_error_flag, 1'b0);
  endtask : clear_fault
  task automatic t_short();
    i_ce = 1'b0;
    {i_pwm_on, i_short_cmp} = 8'h11;
    wait_n(20);
    chk(o_channel_short_flag, 4'h0);
    i_ce = 1'b1;
    {i_pwm_on, i_short_cmp} = 8'h11;
    wait_n(6);
    i_pwm_on = 4'h0;
    wait_n(20);
    chk(o_channel_short_flag, 4'h0);
    i_pwm_on = 4'h1;
    wait_n(14);
    chk({o_channel_short_flag, o_out_flag, o_err_flag, o_err_pin_oe}, 7'h0F);
    {i_pwm_on, i_short_cmp} = 8'h00;
    wait_n(30);
    chk({o_channel_short_flag, o_err_pin_oe}, 5'h02);
    clear_fault();
    $display("short test done");
  endtask : t_short
  task automatic t_sls();
    {i_channel_threshold_select, i_sls_cmp1, i_pwm_on} = 12'h266;
    wait_n(20);
    chk(o_channel_single_led_flag, 4'h0);
    {i_single_led_short_enable, i_low_supply} = 2'h3;
    wait_n(20);
    chk(o_channel_single_led_flag, 4'h0);
    i_low_supply = 1'b0;
    wait_n(20);
    chk({o_channel_single_led_flag, o_out_flag, o_err_flag}, 6'h0B);
    i_sls_cmp0 = 4'h4;
    wait_n(20);
    chk({o_channel_single_led_flag, o_out_flag, o_err_flag}, 6'h1B);
    {i_pwm_on, i_sls_cmp1, i_sls_cmp0} = 12'h000;
    wait_n(20);
    clear_fault();
    $display("single-led test done");
  endtask : t_sls
  task automatic t_watchdog();
    chk(o_failsafe_flag, 1'b0);
    fork
      host_u.frame();
      begin
        @(negedge i_clk);
        i_watchdog_period_setting = 4'h1;
      end
    join
    repeat (6) host_u.frame();
    chk(o_failsafe_flag, 1'b0);
    wait_n(15);
    chk(o_failsafe_flag, 1'b1);
    host_u.frame();
    host_u.write_cmd(3'h2);
    wait_n(2);
    chk(o_failsafe_flag, 1'b0);
    i_watchdog_period_setting = 4'hF;
    wait_n(3);
    chk(o_failsafe_flag, 1'b1);
    i_watchdog_period_setting = 4'h0;
    host_u.write_cmd(3'h2);
    wait_n(2);
    chk(o_failsafe_flag, 1'b0);
    $display("watchdog test done");
  endtask : t_watchdog

  initial begin
    {i_ce, i_low_supply, i_single_led_short_enable, i_nvm_valid, i_trim_valid} = 5'h10;
    {i_pwm_on, i_short_cmp, i_sls_cmp0, i_sls_cmp1, i_channel_threshold_select} = 20'h0_0000;
    {i_blank_cyc, i_short_deg_cyc, i_sls_deg_cyc} = {12'h004, 12'h004, 12'h004};
    i_watchdog_period_setting = 4'h0;
    i_nvm_data = 8'h00;
    i_trim_data = 9'h000;
    i_rst_n = 1'b0;
    wait_n(8);
    i_rst_n = 1'b1;
    load_nvm(1'b0);
    t_short();
    t_sls();
    host_u.write_cmd(3'h4);
    load_nvm(1'b1);
    clear_fault();
    t_watchdog();
    complete_run();
  end
endmodule : led_fault_diag_watchdog_tb_top
`default_nettype wire
